// ### testbench/cpu_seq_model.sv
`timescale 1ns/10ps
`default_nettype none

module cpu_seq_model #(
   parameter int HANDLER_LEN = 20
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // bench control
   input wire logic run_i,
   input wire logic pc_flag_i,
   input wire logic [1:0] ilen_i,
   input wire logic [15:0] start_pc_i,
   // break unit side
   input wire logic swi_load_i,
   input wire logic [15:0] vector_i,
   // cpu bus
   output logic [15:0] addr_o,
   output logic pc_addr_o,
   output logic last_cycle_o,
   output logic rti_o
);
   logic [15:0] pc_reg;
   logic [1:0] cyc_reg;
   logic [5:0] hcnt_reg;

   // ----------
   // instruction sequencer
   // ----------
   // idle bus keeps moving so a stale address never looks like a held match
   always_ff @(posedge clk_i) begin
      rti_o <= 1'b0;
      last_cycle_o <= 1'b0;
      if (srst_i) begin
         addr_o <= 16'hC3A5;
         pc_addr_o <= 1'b0;
         hcnt_reg <= 6'h00;
         cyc_reg <= 2'h0;
         pc_reg <= start_pc_i;
      end else if (swi_load_i) begin
         // swi replaces the next opcode, fetch moves to the vector
         hcnt_reg <= 6'(HANDLER_LEN);
         addr_o <= vector_i;
         pc_addr_o <= 1'b1;
         cyc_reg <= 2'h0;
      end else if (hcnt_reg != 6'h00) begin
         // handler body, closed by return from interrupt
         hcnt_reg <= hcnt_reg - 6'h01;
         addr_o <= addr_o + 16'h0001;
         rti_o <= (hcnt_reg == 6'h01);
      end else if (!run_i) begin
         addr_o <= addr_o + 16'h3B1D;
         pc_addr_o <= 1'b0;
         pc_reg <= start_pc_i;
         cyc_reg <= 2'h0;
      end else begin
         // opcode fetch on first cycle, operand cycles in data space
         addr_o <= (cyc_reg == 2'h0) ? pc_reg : {14'h2000, cyc_reg};
         pc_addr_o <= (cyc_reg == 2'h0) && pc_flag_i;
         last_cycle_o <= (cyc_reg == ilen_i);
         cyc_reg <= (cyc_reg == ilen_i) ? 2'h0 : cyc_reg + 2'h1;
         if (cyc_reg == ilen_i) begin
            pc_reg <= pc_reg + 16'h0001;
         end
      end
   end
endmodule

`default_nettype wire

// ### testbench/tb_address_breakpoint_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "brk_map.svh"

module tb_address_breakpoint_unit;
   // ----------
   // stimulus and observed signals
   // ----------
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [2:0] reg_addr_i = 3'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic monitor_mode_i = 1'b0;
   logic core_wait_i = 1'b0;
   logic core_stop_i = 1'b0;
   logic test_high_voltage_i = 1'b0;
   logic run = 1'b0;
   logic clk_en = 1'b1;
   logic pc_flag = 1'b1;
   logic [1:0] ilen = 2'h0;
   logic [15:0] start_pc = 16'h0000;
   logic [7:0] reg_rdata_o;
   logic [15:0] cpu_addr;
   logic [15:0] vector_addr_o;
   logic cpu_pc, cpu_last, cpu_rti, break_req_o, swi_load_o, break_state_o;
   logic timer_one_halt_o, timer_two_halt_o, watchdog_disable_o;
   logic lowpower_exit_o, clear_flags_allowed_o, hit;
   logic [31:0] seed = 32'hAFC05039;
   logic [15:0] bp;
   int bad_count = 0;
   int n_tests = 0;
   int regs [8] = '{default: 0};
   int rmask [8] = '{8'hC0, 8'hFF, 8'hFF, 8'h02, 8'h80, 0, 0, 0};

   always #4 ref_clk_i = ~ref_clk_i;

   address_breakpoint_unit uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .clk_en_i(clk_en),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cpu_addr_i(cpu_addr),
      .cpu_pc_addr_i(cpu_pc), .cpu_last_cycle_i(cpu_last), .cpu_rti_i(cpu_rti),
      .monitor_mode_i(monitor_mode_i), .core_wait_i(core_wait_i),
      .core_stop_i(core_stop_i), .test_high_voltage_i(test_high_voltage_i),
      .break_req_o(break_req_o), .swi_load_o(swi_load_o), .vector_addr_o(vector_addr_o),
      .break_state_o(break_state_o), .timer_one_halt_o(timer_one_halt_o),
      .timer_two_halt_o(timer_two_halt_o), .watchdog_disable_o(watchdog_disable_o),
      .lowpower_exit_o(lowpower_exit_o), .clear_flags_allowed_o(clear_flags_allowed_o));

   cpu_seq_model cpu (.clk_i(ref_clk_i), .srst_i(srst_i), .run_i(run), .pc_flag_i(pc_flag),
      .ilen_i(ilen), .start_pc_i(start_pc), .swi_load_i(swi_load_o),
      .vector_i(vector_addr_o), .addr_o(cpu_addr), .pc_addr_o(cpu_pc),
      .last_cycle_o(cpu_last), .rti_o(cpu_rti));

   // ----------
   // helpers
   // ----------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // register writes also update the bench's copy; status wake bit only clears
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
      if (a == 3'h3) begin
         regs[3] = regs[3] & d;
      end else begin
         regs[a] = d & rmask[a];
      end
   endtask

   task automatic rd_chk(input logic [2:0] a);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      @(negedge ref_clk_i);
      chk("read data", {8'h00, reg_rdata_o}, 16'(regs[a]));
   endtask

   // bounded wait: 0 request, 1 break over, 2 swi load
   task automatic wait_sig(input int which, input int lim);
      logic got;
      got = 1'b0;
      for (int i = 0; i < lim && !got; i++) begin
         @(negedge ref_clk_i);
         case (which)
            0: got = (break_req_o === 1'b1);
            1: got = (break_state_o === 1'b0);
            default: got = (swi_load_o === 1'b1);
         endcase
      end
      if (!got) begin
         bad_count++;
         $display("unexpected wait %0d expected event seen none", which);
         tally_and_finish();
      end
   endtask

   task automatic quiet(input int n);
      hit = 1'b0;
      repeat (n) begin
         @(negedge ref_clk_i);
         hit = hit | break_req_o;
      end
      chk("quiet request", {15'h0000, hit}, 16'h0000);
   endtask

   task automatic go(input logic [1:0] il, input logic pcf);
      @(posedge ref_clk_i);
      ilen <= il;
      pc_flag <= pcf;
      run <= 1'b1;
   endtask

   task automatic stop();
      @(posedge ref_clk_i);
      run <= 1'b0;
   endtask

   // ----------
   // main sequence
   // ----------
   initial begin
      repeat (4) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      for (int a = 0; a < 8; a++) begin
         rd_chk(3'(a));
      end
      chk("vector", vector_addr_o, `BRK_VEC_NORMAL);
      chk("clear allowed", {15'h0000, clear_flags_allowed_o}, 16'h0001);
      // breakpoint kept below the operand and vector areas
      seed = xs(seed);
      bp = {1'b0, seed[14:0]} | 16'h0010;
      start_pc <= bp - 16'h0003;
      wr(3'h1, bp[15:8]);
      wr(3'h2, bp[7:0]);
      wr(3'h6, seed[23:16]);
      wr(3'h3, 8'hFF);
      for (int a = 1; a < 8; a++) begin
         rd_chk(3'(a));
      end
      go(2'h0, 1'b1);
      quiet(12);
      stop();
      wr(3'h0, 8'h80);
      rd_chk(3'h0);
      go(2'h0, 1'b0);
      quiet(12);
      stop();
      // hit on a last cycle, test level present
      go(2'h0, 1'b1);
      test_high_voltage_i <= 1'b1;
      wait_sig(0, 20);
      chk("swi load", {15'h0000, swi_load_o}, 16'h0001);
      @(negedge ref_clk_i);
      chk("break state", {15'h0000, break_state_o}, 16'h0001);
      chk("request", {15'h0000, break_req_o}, 16'h0000);
      chk("timer halts", {14'h0000, timer_one_halt_o, timer_two_halt_o}, 16'h0003);
      chk("clear allowed", {15'h0000, clear_flags_allowed_o}, 16'h0000);
      wr(3'h4, 8'h80);
      @(negedge ref_clk_i);
      chk("clear allowed", {15'h0000, clear_flags_allowed_o}, 16'h0001);
      chk("watchdog off", {15'h0000, watchdog_disable_o}, 16'h0001);
      chk("vector", vector_addr_o, `BRK_VEC_NORMAL);
      regs[0] = 8'hC0;
      wait_sig(1, 40);
      stop();
      rd_chk(3'h0);
      wr(3'h0, 8'h80);
      rd_chk(3'h0);
      rd_chk(3'h4);
      wr(3'h4, 8'h00);
      // hit on the first of three cycles waits for the instruction end
      go(2'h2, 1'b1);
      test_high_voltage_i <= 1'b0;
      wait_sig(0, 30);
      chk("swi load", {15'h0000, swi_load_o}, 16'h0000);
      wait_sig(2, 3);
      @(negedge ref_clk_i);
      chk("watchdog off", {15'h0000, watchdog_disable_o}, 16'h0000);
      regs[0] = 8'hC0;
      wait_sig(1, 40);
      stop();
      wr(3'h0, 8'h80);
      // software break while stopped wakes the core
      @(posedge ref_clk_i);
      core_stop_i <= 1'b1;
      wr(3'h0, 8'hC0);
      @(negedge ref_clk_i);
      chk("request", {15'h0000, break_req_o}, 16'h0001);
      chk("wake exit", {15'h0000, lowpower_exit_o}, 16'h0001);
      @(posedge ref_clk_i);
      core_stop_i <= 1'b0;
      regs[3] = 8'h02;
      wait_sig(1, 40);
      rd_chk(3'h3);
      wr(3'h3, 8'h00);
      rd_chk(3'h3);
      wr(3'h0, 8'h80);
      // address break in wait mode, monitor vector
      go(2'h0, 1'b1);
      core_wait_i <= 1'b1;
      monitor_mode_i <= 1'b1;
      wait_sig(0, 20);
      chk("wake exit", {15'h0000, lowpower_exit_o}, 16'h0001);
      @(negedge ref_clk_i);
      chk("vector", vector_addr_o, `BRK_VEC_MONITOR);
      @(posedge ref_clk_i);
      core_wait_i <= 1'b0;
      regs[0] = 8'hC0;
      regs[3] = 8'h02;
      wait_sig(1, 40);
      stop();
      // a write while the enable is low must leave the address byte alone
      clk_en <= 1'b0;
      wr(3'h1, ~bp[15:8]);
      clk_en <= 1'b1;
      regs[1] = bp[15:8];
      for (int a = 0; a < 5; a++) begin
         rd_chk(3'(a));
      end
      tally_and_finish();
   end
endmodule

`default_nettype wire

// ### verilog/address_breakpoint_unit.sv
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "brk_map.svh"

module address_breakpoint_unit (
   // clock, reset, enable
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic clk_en_i,
   // register port
   input wire logic [2:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // cpu address bus and sequencer
   input wire logic [15:0] cpu_addr_i,
   input wire logic cpu_pc_addr_i,
   input wire logic cpu_last_cycle_i,
   input wire logic cpu_rti_i,
   input wire logic monitor_mode_i,
   input wire logic core_wait_i,
   input wire logic core_stop_i,
   // reset pin test level, asynchronous
   input wire logic test_high_voltage_i,
   // break outputs
   output logic break_req_o,
   output logic swi_load_o,
   output logic [15:0] vector_addr_o,
   output logic break_state_o,
   output logic timer_one_halt_o,
   output logic timer_two_halt_o,
   output logic watchdog_disable_o,
   output logic lowpower_exit_o,
   output logic clear_flags_allowed_o
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   brk_pkg::brk_state_t state_reg;
   brk_pkg::brk_state_t state_next;
   logic breakpoint_enable_reg;
   logic break_active_reg;
   logic [7:0] break_address_high_reg;
   logic [7:0] break_address_low_reg;
   logic woke_by_break_reg;
   logic clear_flags_in_break_enable_reg;
   logic match_reg;
   logic match_last_reg;
   logic tst_meta_reg;
   logic tst_sync_reg;
   logic [7:0] rdata_reg;
   logic [15:0] vector_reg;
   logic wr_ctrl;
   logic sw_break;
   logic addr_hit;
   logic start_now;
   logic lowpower;

   // ---------------------------------------------------------------
   // register decode
   // ---------------------------------------------------------------
   // a write to the control byte with the active bit high forces a break
   assign wr_ctrl = reg_wr_i && (reg_addr_i == `BRK_OFS_STATUS_CONTROL);
   assign sw_break = wr_ctrl && reg_wdata_i[`BRK_BIT_ACTIVE];

   // ---------------------------------------------------------------
   // test level synchroniser
   // ---------------------------------------------------------------
   // the pin level is asynchronous, so two flops before anyone reads it
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         tst_meta_reg <= 1'b0;
         tst_sync_reg <= 1'b0;
      end else if (clk_en_i) begin
         tst_meta_reg <= test_high_voltage_i;
         tst_sync_reg <= tst_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // address comparator
   // ---------------------------------------------------------------
   // only program counter cycles count; data cycles could alias the address
   assign addr_hit = breakpoint_enable_reg && cpu_pc_addr_i &&
      (cpu_addr_i == {break_address_high_reg, break_address_low_reg});

   // compare is registered: one request per matching bus cycle, and the
   // clock keeps running in wait mode so breaks still fire there
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         match_reg <= 1'b0;
         match_last_reg <= 1'b0;
      end else if (clk_en_i) begin
         match_reg <= addr_hit;
         match_last_reg <= cpu_last_cycle_i;
      end
   end

   // ---------------------------------------------------------------
   // break sequencer
   // ---------------------------------------------------------------
   // a last cycle match starts at once, but only from idle so that a match
   // inside the handler never injects a second opcode
   assign start_now = match_reg && match_last_reg &&
      (state_reg == brk_pkg::BRK_IDLE);
   assign lowpower = core_wait_i || core_stop_i;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         brk_pkg::BRK_IDLE: begin
            if (start_now) begin
               state_next = brk_pkg::BRK_ACTIVE;
            end else if (match_reg || sw_break) begin
               state_next = brk_pkg::BRK_PENDING;
            end
         end
         brk_pkg::BRK_PENDING: begin
            // opcode is injected once the current instruction completes, or at once while the core is in wait or stop
            if (cpu_last_cycle_i || lowpower) begin
               state_next = brk_pkg::BRK_ACTIVE;
            end
         end
         brk_pkg::BRK_ACTIVE: begin
            if (cpu_rti_i) begin
               state_next = brk_pkg::BRK_IDLE;
            end
         end
         default: begin
            state_next = brk_pkg::BRK_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state_reg <= brk_pkg::BRK_IDLE;
      end else if (clk_en_i) begin
         state_reg <= state_next;
      end
   end

   // request and opcode injection towards the cpu
   assign break_req_o = match_reg || (state_reg == brk_pkg::BRK_PENDING);
   assign swi_load_o = start_now || ((state_reg == brk_pkg::BRK_PENDING) &&
      (cpu_last_cycle_i || lowpower));
   // a break taken while the core sleeps also wakes it up
   assign lowpower_exit_o = swi_load_o && lowpower;

   // ---------------------------------------------------------------
   // vector select
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         vector_reg <= `BRK_VEC_NORMAL;
      end else if (clk_en_i) begin
         vector_reg <= monitor_mode_i ? `BRK_VEC_MONITOR : `BRK_VEC_NORMAL;
      end
   end
   assign vector_addr_o = vector_reg;

   // ---------------------------------------------------------------
   // break side effects
   // ---------------------------------------------------------------
   assign break_state_o = (state_reg == brk_pkg::BRK_ACTIVE);
   assign timer_one_halt_o = break_state_o;
   assign timer_two_halt_o = break_state_o;
   // watchdog keeps running unless a break is active and the bench holds test voltage on reset
   assign watchdog_disable_o = break_state_o && tst_sync_reg;
   // outside a break flags always clear; inside only when permitted
   assign clear_flags_allowed_o = !break_state_o || clear_flags_in_break_enable_reg;

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         breakpoint_enable_reg <= 1'b0;
      end else if (clk_en_i && wr_ctrl) begin
         breakpoint_enable_reg <= reg_wdata_i[`BRK_BIT_ENABLE];
      end
   end

   // hardware set beats a software clear in the same cycle
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         break_active_reg <= 1'b0;
      end else if (clk_en_i) begin
         if (match_reg || sw_break) begin
            break_active_reg <= 1'b1;
         end else if (wr_ctrl) begin
            break_active_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // breakpoint address bytes
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         break_address_high_reg <= `BRK_RST_BYTE;
         break_address_low_reg <= `BRK_RST_BYTE;
      end else if (clk_en_i && reg_wr_i) begin
         if (reg_addr_i == `BRK_OFS_ADDRESS_HIGH) begin
            break_address_high_reg <= reg_wdata_i;
         end
         if (reg_addr_i == `BRK_OFS_ADDRESS_LOW) begin
            break_address_low_reg <= reg_wdata_i;
         end
      end
   end

   // ---------------------------------------------------------------
   // wake status and flag clear control
   // ---------------------------------------------------------------
   // wake flag: set wins over the software zero write
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         woke_by_break_reg <= 1'b0;
      end else if (clk_en_i) begin
         if (lowpower_exit_o) begin
            woke_by_break_reg <= 1'b1;
         end else if (reg_wr_i && (reg_addr_i == `BRK_OFS_WAKE_STATUS) &&
                      !reg_wdata_i[`BRK_BIT_WOKE]) begin
            woke_by_break_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         clear_flags_in_break_enable_reg <= 1'b0;
      end else if (clk_en_i && reg_wr_i && (reg_addr_i == `BRK_OFS_FLAG_CLEAR)) begin
         clear_flags_in_break_enable_reg <= reg_wdata_i[`BRK_BIT_CLEAR_EN];
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   // data stands only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rdata_reg <= `BRK_RST_BYTE;
      end else if (clk_en_i) begin
         rdata_reg <= `BRK_RST_BYTE;
         if (reg_rd_i) begin
            case (reg_addr_i)
               `BRK_OFS_STATUS_CONTROL: begin
                  rdata_reg[`BRK_BIT_ENABLE] <= breakpoint_enable_reg;
                  rdata_reg[`BRK_BIT_ACTIVE] <= break_active_reg;
               end
               `BRK_OFS_ADDRESS_HIGH: begin
                  rdata_reg <= break_address_high_reg;
               end
               `BRK_OFS_ADDRESS_LOW: begin
                  rdata_reg <= break_address_low_reg;
               end
               `BRK_OFS_WAKE_STATUS: begin
                  // the handler checks this before rewinding its return address
                  rdata_reg[`BRK_BIT_WOKE] <= woke_by_break_reg;
               end
               `BRK_OFS_FLAG_CLEAR: begin
                  rdata_reg[`BRK_BIT_CLEAR_EN] <= clear_flags_in_break_enable_reg;
               end
               default: begin
                  rdata_reg <= `BRK_RST_BYTE;
               end
            endcase
         end
      end
   end
   assign reg_rdata_o = rdata_reg;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   // a registered match needs an enabled pc cycle on the programmed address
   match_cause_a: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      $rose(match_reg) |-> $past(clk_en_i) && $past(breakpoint_enable_reg) &&
         $past(cpu_pc_addr_i) &&
         ($past(cpu_addr_i) == {break_address_high_reg, break_address_low_reg}))
      else $error("match without enabled pc address hit");

   // data cycles on the breakpoint address never raise a match
   pc_only_a: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && !cpu_pc_addr_i |=> !match_reg)
      else $error("non-pc cycle produced a match");

   // pending break turns into the opcode load on the instruction end
   swi_inject_a: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && state_reg == brk_pkg::BRK_PENDING && cpu_last_cycle_i
      |-> swi_load_o ##1 break_state_o)
      else $error("pending break not injected at instruction end");

   // vector follows the monitor mode strap one cycle later
   vector_pick_a: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i |=> vector_addr_o ==
         ($past(monitor_mode_i) ? `BRK_VEC_MONITOR : `BRK_VEC_NORMAL))
      else $error("wrong break vector");

   // match on the last cycle starts the break with no pending phase
   immediate_start_a: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && state_reg == brk_pkg::BRK_IDLE && match_reg && match_last_reg
      |-> swi_load_o ##1 state_reg == brk_pkg::BRK_ACTIVE)
      else $error("last cycle match did not start at once");

   // return from interrupt leaves the break state on the next edge
   rti_exit_a: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && break_state_o && cpu_rti_i |=> !break_state_o && !timer_one_halt_o)
      else $error("break not ended by return");

   // a software write of one raises the active bit and a break
   sw_break_a: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && sw_break && state_reg == brk_pkg::BRK_IDLE
      |=> break_active_reg && state_reg != brk_pkg::BRK_IDLE)
      else $error("software break ignored");

   // the active bit only falls on a zero write
   active_clear_a: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      $fell(break_active_reg) |-> $past(wr_ctrl) && !$past(match_reg))
      else $error("active bit cleared without write");

   // with the enable low no match can appear
   enable_gate_a: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && !breakpoint_enable_reg |=> !match_reg)
      else $error("match while disabled");

   // reset empties the address bytes
   addr_reset_a: assert property (
      @(posedge ref_clk_i)
      srst_i |=> {break_address_high_reg, break_address_low_reg} == `BRK_RST_ADDR)
      else $error("address bytes not cleared by reset");

   // both timers halt from the edge after the opcode load
   timer_halt_a: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && swi_load_o |=> timer_one_halt_o && timer_two_halt_o && break_state_o)
      else $error("timers still running in break");

   // watchdog disable follows the pin level two enabled edges back, in a break only
   wdog_gate_a: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      $past(clk_en_i) && $past(clk_en_i, 2)
      |-> watchdog_disable_o == (break_state_o && $past(test_high_voltage_i, 2)))
      else $error("watchdog disable does not follow test level");

   // a break out of stop or wait sets the wake flag next cycle
   wake_flag_a: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && lowpower_exit_o |=> woke_by_break_reg)
      else $error("wake flag not set on low power exit");

   // flag clearing is locked during a break unless enabled
   clear_lock_a: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      break_state_o && !clear_flags_in_break_enable_reg |-> !clear_flags_allowed_o)
      else $error("flags clearable in break while locked");

   // one registered match lasts exactly as long as the hits
   one_request_a: assert property (
      @(posedge ref_clk_i) disable iff (srst_i)
      clk_en_i && addr_hit ##1 clk_en_i && !addr_hit |=> !match_reg)
      else $error("match outlived the bus cycle");

endmodule

`default_nettype wire

// ### verilog/brk_map.svh
`ifndef BRK_MAP_SVH
`define BRK_MAP_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define BRK_OFS_STATUS_CONTROL 3'h0
`define BRK_OFS_ADDRESS_HIGH 3'h1
`define BRK_OFS_ADDRESS_LOW 3'h2
`define BRK_OFS_WAKE_STATUS 3'h3
`define BRK_OFS_FLAG_CLEAR 3'h4

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define BRK_BIT_ENABLE 7
`define BRK_BIT_ACTIVE 6
`define BRK_BIT_WOKE 1
`define BRK_BIT_CLEAR_EN 7

// ---------------------------------------------------------------
// reset values and vectors
// ---------------------------------------------------------------
`define BRK_RST_BYTE 8'h00
`define BRK_RST_ADDR 16'h0000
`define BRK_VEC_NORMAL 16'hFFFC
`define BRK_VEC_MONITOR 16'hFEFC

`endif

// ### verilog/brk_pkg.sv
package brk_pkg;
   // break sequencer states, gray along idle -> pending -> active
   typedef enum logic [1:0] {
      BRK_IDLE = 2'h0,
      BRK_PENDING = 2'h1,
      BRK_ACTIVE = 2'h3
   } brk_state_t;
endpackage
